// [logic/pwt_top.sv]
// pwm and pulse-train output channel with an AXI4-Lite register slave
// assumes a single 20 MHz aclk and synchronous active-low reset
// Overview of operation
// - current control reads setpoint as ratio of reference; the code ignores PWT_CTRL_CUR and reads setpoint as duty
// - reference current capped 4000 or 2000 mA
// - staged target 1 sets pwm period
// - staged target 2 delays first pulse
// - pulse train emits exactly setpoint pulses
// - staged target 1 sets train period
// - staged target 4 sets train duty
// - duty above full scale saturates, no error
// - percent format full scale 100
// - per-thousand format full scale 1000
// - per-ten-thousand format full scale 10000
// - analog format full scale 27648
// - pwm setpoint is duty, scaled by format
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pwt_regs.svh"
module pwt_top (
    input wire aclk,
    input wire aresetn,
    input pwt_pkg::pwt_axi_req_t axi_req,
    output pwt_pkg::pwt_axi_rsp_t axi_rsp,
    output logic drive_out
);
    pwt_pkg::pwt_state_t st_ff;
    pwt_pkg::pwt_state_t nxt_st;
    logic [15:0] full;
    logic [31:0] duty_src;
    logic [31:0] duty_eff;
    logic [15:0] ref_lim;
    logic tick;
    logic hi;
    logic train;
    logic wr_fire;
    logic ld_v;
    logic [3:0] ld_tgt;
    logic [31:0] ld_val;
    logic wrap;
    logic [31:0] rd_data;
    logic rd_err;
    logic [7:0] wa;
    logic [7:0] ra;
    logic pend_set;
    logic [31:0] ref_w;

    function automatic logic [31:0] pwt_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign train = st_ff.ctrl[`PWT_CTRL_MODE];
    assign tick = (st_ff.div == 5'(`PWT_TICK_CYC - 1));
    assign ref_lim = st_ff.ctrl[`PWT_CTRL_PAR] ? `PWT_REF_MAX_PAR : `PWT_REF_MAX_CH;
    assign wa = st_ff.waddr[7:0];
    assign ra = axi_req.araddr[7:0];
    assign ref_w = pwt_merge({16'h0, st_ff.ref_ma}, st_ff.wdata, st_ff.wstrb);
    assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid;
    assign wrap = (st_ff.fsm == pwt_pkg::PWT_RUN) && tick && (st_ff.cnt + 32'h1 >= st_ff.period);

    always_comb begin
        case (st_ff.ctrl[`PWT_CTRL_FMT])
            2'h0: full = `PWT_FS_PCT;
            2'h1: full = `PWT_FS_PERMIL;
            2'h2: full = `PWT_FS_P10K;
            default: full = `PWT_FS_ANA;
        endcase
    end

    // train uses staged duty, pwm uses setpoint as duty (same reading with or without current control)
    assign duty_src = train ? st_ff.duty : st_ff.outval;
    assign duty_eff = (duty_src > {16'h0, full}) ? {16'h0, full} : duty_src;
    assign hi = (48'(st_ff.cnt) * 48'(full)) < (48'(duty_eff) * 48'(st_ff.period));

    always_comb begin
        rd_data = 32'h0;
        rd_err = 1'b0;
        if (axi_req.araddr[31:8] != 24'h0) begin
            rd_err = 1'b1;
        end else if (ra == `PWT_A_CTRL) begin
            rd_data = st_ff.ctrl;
        end else if (ra == `PWT_A_OUTVAL) begin
            rd_data = st_ff.outval;
        end else if (ra == `PWT_A_SLOT) begin
            rd_data = st_ff.slot;
        end else if (ra == `PWT_A_SLOTCTL) begin
            rd_data = {27'h0, st_ff.slotctl};
        end else if (ra == `PWT_A_REF) begin
            rd_data = {16'h0, st_ff.ref_ma};
        end else if (ra == `PWT_A_STATUS) begin
            rd_data = {27'h0, st_ff.pend_v, 1'b0, st_ff.dq, st_ff.fsm};
        end else if (ra == `PWT_A_LEFT) begin
            rd_data = st_ff.left;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        ld_v = 1'b0;
        ld_tgt = 4'h0;
        ld_val = 32'h0;
        pend_set = 1'b0;
        // write channel
        if (axi_req.awvalid && st_ff.rsp.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_ff.rsp.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = axi_req.wdata;
            nxt_st.wstrb = axi_req.wstrb;
        end
        if (st_ff.rsp.bvalid && axi_req.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = `PWT_RESP_OK;
            if (st_ff.waddr[31:8] != 24'h0) begin
                nxt_st.rsp.bresp = `PWT_RESP_DECERR;
            end else if (wa == `PWT_A_CTRL) begin
                nxt_st.ctrl = pwt_merge(st_ff.ctrl, st_ff.wdata, st_ff.wstrb);
            end else if (wa == `PWT_A_OUTVAL) begin
                nxt_st.outval = pwt_merge(st_ff.outval, st_ff.wdata, st_ff.wstrb);
            end else if (wa == `PWT_A_SLOT) begin
                nxt_st.slot = pwt_merge(st_ff.slot, st_ff.wdata, st_ff.wstrb);
            end else if (wa == `PWT_A_SLOTCTL) begin
                if (st_ff.wstrb[0]) begin
                    nxt_st.slotctl = st_ff.wdata[4:0];
                    // mode 0 loads now, mode 1 at the next period boundary
                    if (st_ff.wdata[`PWT_SC_SMODE]) begin
                        nxt_st.pend_v = 1'b1;
                        pend_set = 1'b1;
                        nxt_st.pend_tgt = st_ff.wdata[`PWT_SC_TGT];
                        nxt_st.pend_val = st_ff.slot;
                    end else begin
                        ld_v = 1'b1;
                        ld_tgt = st_ff.wdata[`PWT_SC_TGT];
                        ld_val = st_ff.slot;
                    end
                end
            end else if (wa == `PWT_A_REF) begin
                nxt_st.ref_ma = ref_w[15:0];
            end else if (wa != `PWT_A_STATUS && wa != `PWT_A_LEFT) begin
                nxt_st.rsp.bresp = `PWT_RESP_DECERR;
            end
        end
        // limit follows the parallel bit being written, not the old one
        if (nxt_st.ctrl[`PWT_CTRL_PAR]) begin
            if (nxt_st.ref_ma > `PWT_REF_MAX_PAR) begin
                nxt_st.ref_ma = `PWT_REF_MAX_PAR;
            end
        end else if (nxt_st.ref_ma > `PWT_REF_MAX_CH) begin
            nxt_st.ref_ma = `PWT_REF_MAX_CH;
        end
        nxt_st.rsp.awready = !nxt_st.aw_got;
        nxt_st.rsp.wready = !nxt_st.w_got;
        // read channel
        if (st_ff.rsp.rvalid && axi_req.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_ff.rsp.arready) begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata = rd_data;
            nxt_st.rsp.rresp = rd_err ? `PWT_RESP_DECERR : `PWT_RESP_OK;
        end
        nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
        // staged parameter load
        if (!ld_v && wrap && st_ff.pend_v) begin
            ld_v = 1'b1;
            ld_tgt = st_ff.pend_tgt;
            ld_val = st_ff.pend_val;
            // a request written at this boundary stays pending
            if (!pend_set) begin
                nxt_st.pend_v = 1'b0;
            end
        end
        if (ld_v) begin
            if (ld_tgt == `PWT_TGT_PERIOD) begin
                nxt_st.period = ld_val;
            end else if (ld_tgt == `PWT_TGT_DELAY) begin
                nxt_st.delay = ld_val;
            end else if (ld_tgt == `PWT_TGT_DUTY) begin
                nxt_st.duty = ld_val;
            end
        end
        // sequencer
        nxt_st.en_d = st_ff.ctrl[`PWT_CTRL_EN];
        nxt_st.div = tick ? 5'h0 : st_ff.div + 5'h1;
        nxt_st.dq = 1'b0;
        if (!st_ff.ctrl[`PWT_CTRL_EN]) begin
            nxt_st.fsm = pwt_pkg::PWT_IDLE;
        end else if (!st_ff.en_d) begin
            nxt_st.fsm = pwt_pkg::PWT_DELAY;
            nxt_st.dcnt = 32'h0;
            nxt_st.cnt = 32'h0;
            nxt_st.div = 5'h0;
            nxt_st.left = st_ff.outval;
        end else begin
            case (st_ff.fsm)
                pwt_pkg::PWT_DELAY: begin
                    if (st_ff.dcnt >= st_ff.delay) begin
                        // restart the tick so the first period is full length
                        nxt_st.div = 5'h0;
                        nxt_st.cnt = 32'h0;
                        nxt_st.fsm = (train && st_ff.left == 32'h0) ? pwt_pkg::PWT_DONE
                            : pwt_pkg::PWT_RUN;
                    end else if (tick) begin
                        nxt_st.dcnt = st_ff.dcnt + 32'h1;
                    end
                end
                pwt_pkg::PWT_RUN: begin
                    nxt_st.dq = (st_ff.period != 32'h0) && hi;
                    if (tick) begin
                        nxt_st.cnt = st_ff.cnt + 32'h1;
                    end
                    if (wrap) begin
                        nxt_st.cnt = 32'h0;
                        if (train) begin
                            nxt_st.left = st_ff.left - 32'h1;
                            if (st_ff.left == 32'h1) begin
                                nxt_st.fsm = pwt_pkg::PWT_DONE;
                            end
                        end
                    end
                end
                pwt_pkg::PWT_DONE: nxt_st.dq = 1'b0;
                default: nxt_st.dq = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.period <= `PWT_RST_PERIOD;
            st_ff.ref_ma <= `PWT_RST_REF;
            st_ff.fsm <= pwt_pkg::PWT_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign axi_rsp = st_ff.rsp;
    assign drive_out = st_ff.dq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_REF_LIMIT: assert property (st_ff.ref_ma <= ref_lim)
        else $error("reference current above limit");
    AST_DELAY_LOW: assert property (st_ff.fsm == pwt_pkg::PWT_DELAY |=> !drive_out)
        else $error("output high during on-delay");
    AST_DONE_LOW: assert property (st_ff.fsm == pwt_pkg::PWT_DONE |=> !drive_out)
        else $error("output high after pulse train ended");
    AST_TRAIN_STOP: assert property (wrap && train && st_ff.left == 32'h1 && st_ff.en_d
        && st_ff.ctrl[`PWT_CTRL_EN] |=> st_ff.fsm == pwt_pkg::PWT_DONE ##1 !drive_out)
        else $error("train did not stop after last pulse");
    AST_SAT: assert property (st_ff.fsm == pwt_pkg::PWT_RUN && st_ff.period != 32'h0
        && st_ff.cnt < st_ff.period && duty_src > {16'h0, full} |-> hi)
        else $error("duty above full scale not saturated");
    AST_FULL_HIGH: assert property (st_ff.fsm == pwt_pkg::PWT_RUN && st_ff.en_d
        && st_ff.ctrl[`PWT_CTRL_EN] && duty_src >= {16'h0, full} && st_ff.period != 32'h0
        |=> drive_out)
        else $error("full duty did not drive output high");
    AST_RUN_START: assert property (st_ff.fsm == pwt_pkg::PWT_DELAY && st_ff.en_d
        && st_ff.ctrl[`PWT_CTRL_EN] && st_ff.dcnt >= st_ff.delay
        && (!train || st_ff.left != 32'h0) |=> st_ff.fsm == pwt_pkg::PWT_RUN)
        else $error("run did not start after on-delay");
    AST_STAGED: assert property (wrap && st_ff.pend_v && !ld_v
        && st_ff.pend_tgt == `PWT_TGT_PERIOD |=> st_ff.period == $past(st_ff.pend_val))
        else $error("staged period not applied at period end");
    AST_PCT: assert property (st_ff.ctrl[`PWT_CTRL_FMT] == 2'h0 |-> full == 16'd100)
        else $error("percent full scale wrong");
    AST_ANA: assert property (st_ff.ctrl[`PWT_CTRL_FMT] == 2'h3 |-> full == 16'd27648)
        else $error("analog full scale wrong");
    AST_PERIOD: assert property (st_ff.fsm == pwt_pkg::PWT_RUN && st_ff.period != 32'h0
        |-> st_ff.cnt < st_ff.period)
        else $error("period counter overran period");
    AST_ZERO_DUTY: assert property (st_ff.fsm == pwt_pkg::PWT_RUN && duty_eff == 32'h0
        && !train |=> !drive_out)
        else $error("zero duty drove output");
    AST_BHOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
        else $error("write response dropped");
    AST_RLAT: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");

    COV_TRAIN_DONE: cover property (st_ff.fsm == pwt_pkg::PWT_RUN ##1
        st_ff.fsm == pwt_pkg::PWT_DONE);
    COV_PWM_PULSE: cover property (!train && $rose(drive_out));
    COV_STAGED: cover property (wrap && st_ff.pend_v);
    COV_SAT: cover property (st_ff.fsm == pwt_pkg::PWT_RUN && duty_src > {16'h0, full});
    COV_DELAY_RUN: cover property (st_ff.fsm == pwt_pkg::PWT_DELAY && st_ff.delay != 32'h0
        ##1 st_ff.fsm == pwt_pkg::PWT_RUN);
endmodule

// [logic/pwt_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz aclk and a 1 us timebase for all staged times
`ifndef PWT_REGS_SVH
`define PWT_REGS_SVH
`define PWT_A_CTRL 8'h00
`define PWT_A_OUTVAL 8'h04
`define PWT_A_SLOT 8'h08
`define PWT_A_SLOTCTL 8'h0c
`define PWT_A_REF 8'h10
`define PWT_A_STATUS 8'h14
`define PWT_A_LEFT 8'h18
`define PWT_CTRL_EN 0
`define PWT_CTRL_MODE 1
`define PWT_CTRL_CUR 2
`define PWT_CTRL_FMT 5:4
`define PWT_CTRL_PAR 8
`define PWT_SC_TGT 3:0
`define PWT_SC_SMODE 4
`define PWT_TGT_PERIOD 4'h1
`define PWT_TGT_DELAY 4'h2
`define PWT_TGT_DUTY 4'h4
`define PWT_FS_PCT 16'h0064
`define PWT_FS_PERMIL 16'h03e8
`define PWT_FS_P10K 16'h2710
`define PWT_FS_ANA 16'h6c00
`define PWT_REF_MAX_PAR 16'h0fa0
`define PWT_REF_MAX_CH 16'h07d0
`define PWT_RST_PERIOD 32'h000003e8
`define PWT_RST_REF 16'h07d0
`define PWT_RESP_OK 2'h0
`define PWT_RESP_DECERR 2'h3
`define PWT_CLK_NS 50
`define PWT_US_NS 1000
`define PWT_TICK_CYC ((`PWT_US_NS + `PWT_CLK_NS - 1) / `PWT_CLK_NS)
`endif

// [logic/pwt_pkg.sv]
// types shared by the pulse output channel
// assumes a 32-bit AXI4-Lite register bus
package pwt_pkg;
    typedef enum logic [1:0] {PWT_IDLE, PWT_DELAY, PWT_RUN, PWT_DONE} pwt_fsm_t;
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } pwt_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pwt_axi_rsp_t;
    typedef struct packed {
        pwt_axi_rsp_t rsp;
        logic aw_got;
        logic w_got;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] ctrl;
        logic [31:0] outval;
        logic [31:0] slot;
        logic [4:0] slotctl;
        logic [15:0] ref_ma;
        logic [31:0] period;
        logic [31:0] delay;
        logic [31:0] duty;
        logic pend_v;
        logic [3:0] pend_tgt;
        logic [31:0] pend_val;
        pwt_fsm_t fsm;
        logic en_d;
        logic [4:0] div;
        logic [31:0] cnt;
        logic [31:0] dcnt;
        logic [31:0] left;
        logic dq;
    } pwt_state_t;
endpackage

// [test/pwt_act.sv]
// actuator stand-in: counts high cycles and rising edges of drive_out
// assumes the same aclk as the channel; clr restarts all counts
`timescale 1ns/100ps
module pwt_act (
    input wire aclk,
    input wire aresetn,
    input wire clr,
    input wire drive_out,
    output logic [31:0] hi_cnt,
    output logic [31:0] rise_cnt,
    output logic [31:0] first_rise
);
    logic prev_ff;
    logic [31:0] age_ff;
    always @(posedge aclk) begin
        if (!aresetn || clr) begin
            hi_cnt <= 32'h0;
            rise_cnt <= 32'h0;
            first_rise <= 32'hffffffff;
            age_ff <= 32'h0;
            prev_ff <= 1'b0;
        end else begin
            age_ff <= age_ff + 32'h1;
            prev_ff <= drive_out;
            if (drive_out) hi_cnt <= hi_cnt + 32'h1;
            if (drive_out && !prev_ff) begin
                rise_cnt <= rise_cnt + 32'h1;
                if (rise_cnt == 32'h0) first_rise <= age_ff;
            end
        end
    end
endmodule

// [test/tb.sv]
// self-checking bench for the pulse output channel
// assumes pwt_top, the pwt_act stand-in and a 20 MHz aclk
`timescale 1ns/100ps
`include "pwt_regs.svh"
module tb;
    logic aclk, aresetn, clr, drive_out;
    pwt_pkg::pwt_axi_req_t axi_req;
    pwt_pkg::pwt_axi_rsp_t axi_rsp;
    logic [31:0] hi_cnt, rise_cnt, first_rise, rd;
    logic [1:0] rs;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    pwt_top dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .drive_out(drive_out));
    pwt_act act_u (.aclk(aclk), .aresetn(aresetn), .clr(clr), .drive_out(drive_out),
        .hi_cnt(hi_cnt), .rise_cnt(rise_cnt), .first_rise(first_rise));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task tally_and_finish;
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog well above the ~13k cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        axi_req.awaddr <= {24'h0, a};
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        rs = axi_rsp.bresp;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge aclk);
        axi_req.araddr <= {24'h0, a};
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        rd = axi_rsp.rdata;
        rs = axi_rsp.rresp;
    endtask
    task load(input logic [3:0] t, input logic [31:0] v);
        wr(`PWT_A_SLOT, v);
        wr(`PWT_A_SLOTCTL, {28'h0, t});
    endtask
    task t_regs;
        rdr(`PWT_A_REF);
        chk("ref_reset", 32'h7d0, rd);
        wr(`PWT_A_REF, 32'h1388);
        rdr(`PWT_A_REF);
        chk("ref_dual", 32'h7d0, rd);
        wr(`PWT_A_CTRL, 32'h100);
        wr(`PWT_A_REF, 32'h1388);
        rdr(`PWT_A_REF);
        chk("ref_par", 32'hfa0, rd);
        rdr(8'h20);
        chk("unmapped_resp", 32'h3, {30'h0, rs});
        chk("unmapped_data", 32'h0, rd);
        wr(8'h20, 32'h0);
        chk("unmapped_wr_resp", 32'h3, {30'h0, rs});
    endtask
    // one full-scale-relative duty over 5 periods of 200 cycles
    task t_pwm(input logic [1:0] f, input logic [31:0] d, input logic c, input logic [31:0] e);
        wr(`PWT_A_CTRL, 32'h0);
        wr(`PWT_A_OUTVAL, d);
        wr(`PWT_A_CTRL, {26'h0, f, 1'b0, c, 1'b0, 1'b1});
        repeat (400) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (1000) @(posedge aclk);
        #1;
        chk("pwm_high", e, hi_cnt);
    endtask
    task t_train;
        wr(`PWT_A_CTRL, 32'h0);
        load(`PWT_TGT_PERIOD, 32'ha);
        load(`PWT_TGT_DUTY, 32'h32);
        load(`PWT_TGT_DELAY, 32'h5);
        wr(`PWT_A_OUTVAL, 32'h3);
        clr <= 1'b1;
        wr(`PWT_A_CTRL, 32'h3);
        clr <= 1'b0;
        repeat (1500) @(posedge aclk);
        #1;
        chk("train_pulses", 32'h3, rise_cnt);
        chk("train_high", 32'h12c, hi_cnt);
        chk("on_delay", 32'h1, {31'h0, first_rise >= 95 && first_rise <= 110});
        chk("idle_out", 32'h0, {31'h0, drive_out});
        rdr(`PWT_A_STATUS);
        chk("train_state", 32'h3, {30'h0, rd[1:0]});
        rdr(`PWT_A_LEFT);
        chk("train_left", 32'h0, rd);
    endtask
    // mode 1 load stays pending while idle, then lands at the first period end
    task t_staged;
        wr(`PWT_A_CTRL, 32'h0);
        wr(`PWT_A_OUTVAL, 32'h32);
        wr(`PWT_A_SLOT, 32'h14);
        wr(`PWT_A_SLOTCTL, {27'h0, 1'b1, `PWT_TGT_PERIOD});
        rdr(`PWT_A_STATUS);
        chk("pend_set", 32'h1, {31'h0, rd[4]});
        wr(`PWT_A_CTRL, 32'h1);
        repeat (600) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (800) @(posedge aclk);
        #1;
        chk("staged_high", 32'h190, hi_cnt);
        rdr(`PWT_A_STATUS);
        chk("pend_clear", 32'h0, {31'h0, rd[4]});
        load(`PWT_TGT_DUTY, 32'hffff);
        chk("sat_no_err", 32'h0, {30'h0, rs});
    endtask
    initial begin
        axi_req = '0;
        clr = 1'b0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        load(`PWT_TGT_PERIOD, 32'ha);
        load(`PWT_TGT_DELAY, 32'h0);
        t_pwm(2'h0, 32'h32, 1'b0, 32'h1f4);
        t_pwm(2'h1, 32'h1f4, 1'b0, 32'h1f4);
        t_pwm(2'h2, 32'h1388, 1'b0, 32'h1f4);
        t_pwm(2'h3, 32'h3600, 1'b0, 32'h1f4);
        t_pwm(2'h0, 32'hc8, 1'b0, 32'h3e8);
        t_pwm(2'h1, 32'h0, 1'b0, 32'h0);
        t_pwm(2'h3, 32'h3600, 1'b1, 32'h1f4);
        t_staged;
        t_train;
        tally_and_finish;
    end
endmodule
